// *** core/pjkl_top.sv ***
// pin-function and pull-up select for general ports j, k and l
//
// What this block does
// RULE_01: port j function register is 16-bit RW, cleared only by power-on reset.
// RULE_02: port k function register is 16-bit RW, cleared only by power-on reset.
// RULE_03: port l function register is 16-bit RW, cleared only by power-on reset.
// RULE_04: pin n uses bits 2n+1 and 2n of its port register.
// RULE_05: port j code 00 is peripheral on pins 0,2,3,6,7, reserved on 1,4,5.
// RULE_06: code 10 selects port input with pull-up on, all three ports.
// RULE_07: code 11 selects port input with pull-up off, all three ports.
// RULE_08: ports j and k code 01 is output; port k code 00 peripheral.
// RULE_09: port l code 00 is peripheral, code 01 reserved; no output mode.
// RULE_10: software keeps port l register at zero when converter or pins 7/6 in use.
// RULE_11: reserved codes leave the pin input-only, undriven, pull-up off.
module pjkl_top (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic CONV_ANALOG,
  output logic [7:0] PJ_PERIPH,
  output logic [7:0] PJ_OE,
  output logic [7:0] PJ_PU,
  output logic [7:0] PK_PERIPH,
  output logic [7:0] PK_OE,
  output logic [7:0] PK_PU,
  output logic [7:0] PL_PERIPH,
  output logic [7:0] PL_PU
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [15:0] port_j_pin_function;
    logic [15:0] port_k_pin_function;
    logic [15:0] port_l_pin_function;
    logic [7:0] j_periph;
    logic [7:0] j_oe;
    logic [7:0] j_pu;
    logic [7:0] k_periph;
    logic [7:0] k_oe;
    logic [7:0] k_pu;
    logic [7:0] l_periph;
    logic [7:0] l_pu;
    logic [23:0] rsv;
    logic guard;
  } pjkl_top_st_t;

  pjkl_top_st_t q, d;

  pjkl_reg_if rif ();
  pjkl_pin_if jif ();
  pjkl_pin_if kif ();
  pjkl_pin_if lif ();

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] lane_merge(logic [15:0] old, logic [31:0] data,
                                             logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) r[7:0] = data[7:0];
    if (strb[1]) r[15:8] = data[15:8];
    return r;
  endfunction : lane_merge

  // ==========================================================================
  // bus slave and decoders
  pjkl_axi_slv u_slv (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .rif(rif.bus)
  );

  assign jif.field = q.port_j_pin_function;
  assign kif.field = q.port_k_pin_function;
  assign lif.field = q.port_l_pin_function;

  pjkl_pin_dec #(.PORT(pjkl_pkg::PORT_J)) u_dec_j (.pif(jif.dec)); // RULE_05
  pjkl_pin_dec #(.PORT(pjkl_pkg::PORT_K)) u_dec_k (.pif(kif.dec)); // RULE_08
  pjkl_pin_dec #(.PORT(pjkl_pkg::PORT_L)) u_dec_l (.pif(lif.dec)); // RULE_09

  // ==========================================================================
  // register access and pin control registers
  always_comb begin
    d = q;
    rif.wr_err = 1'b0;
    rif.rd_err = 1'b0;
    rif.rd_data = '0;
    if (rif.wr_go) begin
      case (rif.wr_addr)
        pjkl_pkg::OFS_J_FUNC: d.port_j_pin_function =
          lane_merge(q.port_j_pin_function, rif.wr_data, rif.wr_strb); // RULE_01
        pjkl_pkg::OFS_K_FUNC: d.port_k_pin_function =
          lane_merge(q.port_k_pin_function, rif.wr_data, rif.wr_strb); // RULE_02
        pjkl_pkg::OFS_L_FUNC: d.port_l_pin_function =
          lane_merge(q.port_l_pin_function, rif.wr_data, rif.wr_strb); // RULE_03
        pjkl_pkg::OFS_STATUS: rif.wr_err = 1'b0;
        default: rif.wr_err = 1'b1;
      endcase
    end
    if (rif.rd_go) begin
      case (rif.rd_addr)
        pjkl_pkg::OFS_J_FUNC: rif.rd_data = {16'h0000, q.port_j_pin_function};
        pjkl_pkg::OFS_K_FUNC: rif.rd_data = {16'h0000, q.port_k_pin_function};
        pjkl_pkg::OFS_L_FUNC: rif.rd_data = {16'h0000, q.port_l_pin_function};
        pjkl_pkg::OFS_STATUS: rif.rd_data = {7'h00, q.guard, q.rsv};
        default: rif.rd_err = 1'b1;
      endcase
    end
    // field i of each register drives pin i
    for (int i = 0; i < 8; i++) begin
      d.j_periph[i] = jif.pin[i].periph; // RULE_04
      d.j_oe[i] = jif.pin[i].oe;
      d.j_pu[i] = jif.pin[i].pu; // RULE_06
      d.k_periph[i] = kif.pin[i].periph;
      d.k_oe[i] = kif.pin[i].oe; // RULE_08
      d.k_pu[i] = kif.pin[i].pu; // RULE_07
      d.l_periph[i] = lif.pin[i].periph;
      d.l_pu[i] = lif.pin[i].pu;
      d.rsv[pjkl_pkg::STAT_RSV_J + i] = jif.pin[i].rsv; // RULE_11
      d.rsv[pjkl_pkg::STAT_RSV_K + i] = kif.pin[i].rsv;
      d.rsv[pjkl_pkg::STAT_RSV_L + i] = lif.pin[i].rsv;
    end
    // flags a port l setting that software should have left at reset
    d.guard = (q.port_l_pin_function != pjkl_pkg::FUNC_RST) &&
      (CONV_ANALOG ||
       q.port_l_pin_function[15:14] == pjkl_pkg::MD_OTHER ||
       q.port_l_pin_function[13:12] == pjkl_pkg::MD_OTHER); // RULE_10
  end

  // only the power-on reset clears the function registers
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) q <= '0; // RULE_01 RULE_02 RULE_03
    else q <= d;
  end

  assign PJ_PERIPH = q.j_periph;
  assign PJ_OE = q.j_oe;
  assign PJ_PU = q.j_pu;
  assign PK_PERIPH = q.k_periph;
  assign PK_OE = q.k_oe;
  assign PK_PU = q.k_pu;
  assign PL_PERIPH = q.l_periph;
  assign PL_PU = q.l_pu;

  // ==========================================================================
  // checks
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  logic wr_j, wr_k, wr_l;
  assign wr_j = rif.wr_go && rif.wr_addr == pjkl_pkg::OFS_J_FUNC;
  assign wr_k = rif.wr_go && rif.wr_addr == pjkl_pkg::OFS_K_FUNC;
  assign wr_l = rif.wr_go && rif.wr_addr == pjkl_pkg::OFS_L_FUNC;

  chk_j_reg_hold: assert property ( // RULE_01
    !wr_j |=> $stable(q.port_j_pin_function))
    else $error("port j register changed without a write");

  chk_k_reg_hold: assert property ( // RULE_02
    !wr_k |=> q.port_k_pin_function == $past(q.port_k_pin_function))
    else $error("port k register changed without a write");

  chk_l_reg_hold: assert property ( // RULE_03
    !wr_l |=> $stable(q.port_l_pin_function))
    else $error("port l register changed without a write");

  chk_field_write: assert property ( // RULE_04
    wr_k && rif.wr_strb[1:0] == 2'h3 |=> q.port_k_pin_function == $past(rif.wr_data[15:0])
    ##1 PK_OE[7] == (q.port_k_pin_function[15:14] == pjkl_pkg::MD_OUT))
    else $error("port k write not mapped onto its pin fields");

  // the pins still hold their reset value one edge after release, so that edge is skipped
  chk_j_periph_pin: assert property ( // RULE_05
    RST_N && q.port_j_pin_function[15:14] == pjkl_pkg::MD_OTHER
    |=> PJ_PERIPH[7] && !PJ_OE[7])
    else $error("port j pin 7 code 00 not peripheral");

  chk_pullup_on: assert property ( // RULE_06
    q.port_l_pin_function[1:0] == pjkl_pkg::MD_IN_PU |=> PL_PU[0] && !PL_PERIPH[0])
    else $error("port l pin 0 code 10 not input with pull-up");

  chk_pullup_off: assert property ( // RULE_07
    q.port_k_pin_function[7:6] == pjkl_pkg::MD_IN_NOPU
    |=> !PK_PU[3] && !PK_OE[3] && !PK_PERIPH[3])
    else $error("port k pin 3 code 11 not bare input");

  chk_k_out_mode: assert property ( // RULE_08
    q.port_k_pin_function[3:2] == pjkl_pkg::MD_OUT |=> PK_OE[1] && !PK_PU[1])
    else $error("port k pin 1 code 01 not output");

  chk_l_no_output: assert property ( // RULE_09
    q.port_l_pin_function[5:4] == pjkl_pkg::MD_OUT
    |=> q.rsv[pjkl_pkg::STAT_RSV_L + 2] && !PL_PU[2] && !PL_PERIPH[2])
    else $error("port l pin 2 code 01 not treated as reserved");

  chk_j_rsv_pin: assert property ( // RULE_11
    RST_N && q.port_j_pin_function[9:8] == pjkl_pkg::MD_OTHER
    |=> !PJ_PERIPH[4] && !PJ_OE[4] && !PJ_PU[4] && q.rsv[pjkl_pkg::STAT_RSV_J + 4])
    else $error("port j pin 4 reserved code drives the pin");

  chk_l_guard_flag: assert property ( // RULE_10
    CONV_ANALOG && q.port_l_pin_function != pjkl_pkg::FUNC_RST |=> q.guard)
    else $error("port l guard flag not raised");

endmodule : pjkl_top

// *** core/pjkl_pkg.sv ***
// constants, types and pin decode shared by the port j/k/l function-select block
package pjkl_pkg;

  // ==========================================================================
  // register map (word aligned byte addresses)
  localparam int unsigned AXI_ADDR_W = 4;
  localparam int unsigned AXI_DATA_W = 32;
  localparam logic [3:0] OFS_J_FUNC = 4'h0;
  localparam logic [3:0] OFS_K_FUNC = 4'h4;
  localparam logic [3:0] OFS_L_FUNC = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  localparam logic [15:0] FUNC_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // field layout
  localparam int unsigned PIN_N = 8;
  localparam int unsigned FIELD_W = 2;
  localparam int unsigned STAT_RSV_J = 0;
  localparam int unsigned STAT_RSV_K = 8;
  localparam int unsigned STAT_RSV_L = 16;
  localparam int unsigned STAT_GUARD = 24;
  // port j pins whose code 00 has no peripheral behind it
  localparam logic [7:0] J_NO_PERIPH = 8'h32;

  typedef enum logic [1:0] {
    MD_OTHER = 2'b00,
    MD_OUT = 2'b01,
    MD_IN_PU = 2'b10,
    MD_IN_NOPU = 2'b11
  } pjkl_mode_t;

  typedef enum logic [1:0] {
    PORT_J = 2'b00,
    PORT_K = 2'b01,
    PORT_L = 2'b10
  } pjkl_port_t;

  typedef struct packed {
    logic periph;
    logic oe;
    logic pu;
    logic rsv;
  } pjkl_pin_t;

  // ==========================================================================
  // per-pin decode; reserved codes leave the pin as a bare input
  function automatic pjkl_pin_t pin_decode(pjkl_port_t port, logic [2:0] pin,
                                           logic [1:0] code);
    pjkl_pin_t p;
    p = '0;
    case (pjkl_mode_t'(code))
      MD_OTHER: begin
        if (port == PORT_J && J_NO_PERIPH[pin]) p.rsv = 1'b1;
        else p.periph = 1'b1;
      end
      MD_OUT: begin
        if (port == PORT_L) p.rsv = 1'b1;
        else p.oe = 1'b1;
      end
      MD_IN_PU: p.pu = 1'b1;
      default: p.pu = 1'b0;
    endcase
    return p;
  endfunction : pin_decode

endpackage : pjkl_pkg

// *** core/pjkl_if.sv ***
// interfaces between the register bus slave, the pin decoders and the top

interface pjkl_pin_if;
  logic [15:0] field;
  pjkl_pkg::pjkl_pin_t [7:0] pin;
  modport ctl (output field, input pin);
  modport dec (input field, output pin);
endinterface : pjkl_pin_if

interface pjkl_reg_if;
  logic wr_go;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_go;
  logic [3:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  modport bus (output wr_go, wr_addr, wr_data, wr_strb, rd_go, rd_addr,
               input wr_err, rd_data, rd_err);
  modport regs (input wr_go, wr_addr, wr_data, wr_strb, rd_go, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface : pjkl_reg_if

// *** core/pjkl_pin_dec.sv ***
// decoder of one port's function register into per-pin controls
module pjkl_pin_dec #(
  parameter pjkl_pkg::pjkl_port_t PORT = pjkl_pkg::PORT_J
) (
  pjkl_pin_if.dec pif
);

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pif.pin[i] = pjkl_pkg::pin_decode(PORT, 3'(i), pif.field[2*i +: 2]);
    end
  end

endmodule : pjkl_pin_dec

// *** core/pjkl_axi_slv.sv ***
// axi4-lite slave front end: one write and one read in flight
module pjkl_axi_slv (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  pjkl_reg_if.bus rif
);

  typedef struct packed {
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_held;
    logic [3:0] ar_addr;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } pjkl_axi_st_t;

  pjkl_axi_st_t q, d;

  assign rif.wr_go = q.aw_held & q.w_held;
  assign rif.wr_addr = q.aw_addr;
  assign rif.wr_data = q.w_data;
  assign rif.wr_strb = q.w_strb;
  assign rif.rd_go = q.ar_held;
  assign rif.rd_addr = q.ar_addr;

  // ==========================================================================
  // channel handshakes
  always_comb begin
    d = q;
    if (awvalid && q.awready) begin
      d.aw_held = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && q.wready) begin
      d.w_held = 1'b1;
      d.w_data = wdata;
      d.w_strb = wstrb;
    end
    if (rif.wr_go) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = rif.wr_err ? pjkl_pkg::RESP_SLVERR : pjkl_pkg::RESP_OKAY;
    end
    if (q.bvalid && bready) d.bvalid = 1'b0;
    if (arvalid && q.arready) begin
      d.ar_held = 1'b1;
      d.ar_addr = araddr;
    end
    if (rif.rd_go) begin
      d.ar_held = 1'b0;
      d.rvalid = 1'b1;
      d.rdata = rif.rd_data;
      d.rresp = rif.rd_err ? pjkl_pkg::RESP_SLVERR : pjkl_pkg::RESP_OKAY;
    end
    if (q.rvalid && rready) d.rvalid = 1'b0;
    d.awready = ~d.aw_held & ~d.bvalid;
    d.wready = ~d.w_held & ~d.bvalid;
    d.arready = ~d.ar_held & ~d.rvalid;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) q <= '0;
    else q <= d;
  end

  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rresp = q.rresp;
  assign rdata = q.rdata;

endmodule : pjkl_axi_slv

// *** tb/pjkl_top_tb_top.sv ***
// self-checking bench for the port j/k/l function-select block over its register bus
module pjkl_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // stimulus signals and counters
  logic clk;
  logic rst_n;
  logic [3:0] awaddr;
  logic awvalid;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic bready;
  logic [3:0] araddr;
  logic arvalid;
  logic rready;
  logic conv;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] pj_per, pj_oe, pj_pu, pk_per, pk_oe, pk_pu, pl_per, pl_pu;
  int n_errors = 0;
  int check_count = 0;
  logic [3:0] ofs [3] = '{pjkl_pkg::OFS_J_FUNC, pjkl_pkg::OFS_K_FUNC, pjkl_pkg::OFS_L_FUNC};
  logic [15:0] v;

  pjkl_top i_pjkl_top (
    .CLK_SYS(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CONV_ANALOG(conv),
    .PJ_PERIPH(pj_per), .PJ_OE(pj_oe), .PJ_PU(pj_pu),
    .PK_PERIPH(pk_per), .PK_OE(pk_oe), .PK_PU(pk_pu),
    .PL_PERIPH(pl_per), .PL_PU(pl_pu)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================================================
  // comparison, verdict and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // both channels offered together, each released at its own handshake edge
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    // bready stays up, so a following call never assigns it twice in one step
    resp = bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    // rready stays up, so a following call never assigns it twice in one step
    resp = rresp;
  endtask : axi_rd

  task automatic wr_chk(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] want_resp);
    logic [1:0] r;
    axi_wr(a, d, s, r);
    chk(32'(r), 32'(want_resp));
  endtask : wr_chk

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] want, input logic [1:0] want_resp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, want);
    chk(32'(r), 32'(want_resp));
  endtask : rd_chk

  // ==========================================================================
  // expected pin controls {periph, oe, pu} and status word
  function automatic logic [2:0] exp_pin(input int port, input int pin, input logic [1:0] c);
    case (c)
      2'b00: return (port == 0 && (pin == 1 || pin == 4 || pin == 5)) ? 3'b000 : 3'b100;
      2'b01: return (port == 2) ? 3'b000 : 3'b010;
      2'b10: return 3'b001;
      default: return 3'b000;
    endcase
  endfunction : exp_pin

  function automatic logic [31:0] exp_stat(input logic [15:0] fj, input logic [15:0] fl,
                                           input logic cv);
    logic [31:0] s;
    s = '0;
    for (int i = 0; i < 8; i++) begin
      s[i] = (fj[2*i+:2] == 2'b00) && (i == 1 || i == 4 || i == 5);
      s[16+i] = (fl[2*i+:2] == 2'b01);
    end
    s[24] = (fl != 16'h0000) && (cv || fl[15:14] == 2'b00 || fl[13:12] == 2'b00);
    return s;
  endfunction : exp_stat

  // compares every pin control and the status word with the given register values
  task automatic pins_chk(input logic [15:0] fj, input logic [15:0] fk, input logic [15:0] fl);
    logic [7:0] w [8];
    logic [7:0] g [8];
    logic [2:0] e;
    repeat (2) @(posedge clk);
    g = '{pj_per, pj_oe, pj_pu, pk_per, pk_oe, pk_pu, pl_per, pl_pu};
    for (int i = 0; i < 8; i++) begin
      e = exp_pin(0, i, fj[2*i+:2]);
      {w[0][i], w[1][i], w[2][i]} = e;
      e = exp_pin(1, i, fk[2*i+:2]);
      {w[3][i], w[4][i], w[5][i]} = e;
      e = exp_pin(2, i, fl[2*i+:2]);
      {w[6][i], w[7][i]} = {e[2], e[0]};
    end
    for (int k = 0; k < 8; k++) chk(32'(g[k]), 32'(w[k]));
    rd_chk(pjkl_pkg::OFS_STATUS, exp_stat(fj, fl, conv), pjkl_pkg::RESP_OKAY);
  endtask : pins_chk

  // ==========================================================================
  // test sequence
  initial begin
    rst_n = 1'b0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = '0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    conv = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int p = 0; p < 3; p++) rd_chk(ofs[p], 32'h0000_0000, pjkl_pkg::RESP_OKAY);
    pins_chk(16'h0000, 16'h0000, 16'h0000);
    // every code on every pin of every port
    for (int c = 0; c < 4; c++) begin
      v = {8{2'(c)}};
      for (int p = 0; p < 3; p++) wr_chk(ofs[p], {16'h0000, v}, 4'hF, pjkl_pkg::RESP_OKAY);
      for (int p = 0; p < 3; p++) rd_chk(ofs[p], {16'h0000, v}, pjkl_pkg::RESP_OKAY);
      pins_chk(v, v, v);
    end
    // mixed codes expose the field positions; port l field 7 left at 00
    wr_chk(ofs[0], 32'h0000_E41B, 4'hF, pjkl_pkg::RESP_OKAY);
    wr_chk(ofs[1], 32'h0000_1BE4, 4'hF, pjkl_pkg::RESP_OKAY);
    wr_chk(ofs[2], 32'h0000_1BE4, 4'hF, pjkl_pkg::RESP_OKAY);
    pins_chk(16'hE41B, 16'h1BE4, 16'h1BE4);
    // upper lane only, upper word ignored
    wr_chk(ofs[0], 32'hFFFF_FFFF, 4'b0010, pjkl_pkg::RESP_OKAY);
    rd_chk(ofs[0], 32'h0000_FF1B, pjkl_pkg::RESP_OKAY);
    // converter in analog use with a nonzero port l register
    wr_chk(ofs[2], 32'h0000_AAAA, 4'hF, pjkl_pkg::RESP_OKAY);
    conv <= 1'b1;
    pins_chk(16'hFF1B, 16'h1BE4, 16'hAAAA);
    conv <= 1'b0;
    pins_chk(16'hFF1B, 16'h1BE4, 16'hAAAA);
    // status is read only, unmapped places refuse
    wr_chk(pjkl_pkg::OFS_STATUS, 32'hFFFF_FFFF, 4'hF, pjkl_pkg::RESP_OKAY);
    wr_chk(4'h2, 32'hFFFF_FFFF, 4'hF, pjkl_pkg::RESP_SLVERR);
    rd_chk(4'h6, 32'h0000_0000, pjkl_pkg::RESP_SLVERR);
    pins_chk(16'hFF1B, 16'h1BE4, 16'hAAAA);
    // a second power-on reset in mid-run clears everything
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'({pj_oe, pk_oe, pk_per}), 32'h0000_0000);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int p = 0; p < 3; p++) rd_chk(ofs[p], 32'h0000_0000, pjkl_pkg::RESP_OKAY);
    pins_chk(16'h0000, 16'h0000, 16'h0000);
    print_verdict();
  end

  // the sequence needs about two hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end

endmodule : pjkl_top_tb_top
